//--- verilog/nv_access_defines.svh
// Offsets, field positions, reset values and timing counts of the data-memory access block
`ifndef NV_ACCESS_DEFINES_SVH
`define NV_ACCESS_DEFINES_SVH

// Word offsets on the register bus
`define NV_CTRL_OFF 8'h00
`define NV_ADDR_OFF 8'h04
`define NV_DATA_OFF 8'h08
`define NV_STAT_OFF 8'h0C

// Control register fields
`define NV_RIE_BIT 3
`define NV_ARM_BIT 2
`define NV_WSTB_BIT 1
`define NV_RSTB_BIT 0

// Status register fields
`define NV_STAT_GIF_BIT 0
`define NV_STAT_SPM_BIT 1
`define NV_STAT_IRQ_BIT 2

// Reset values
`define NV_ADDR_RST 9'h000
`define NV_DATA_RST 8'h00

// Timing, in CPU clock cycles unless stated
`define NV_ARM_CYCLES 3'h4
`define NV_WSTALL_CYCLES 3'h2
`define NV_RSTALL_CYCLES 3'h4
`define NV_PROG_OSC_CYCLES 8448
`define NV_OSC_FREQ_KHZ 1000
`define NV_PROG_TIME_US ((`NV_PROG_OSC_CYCLES * 1000) / `NV_OSC_FREQ_KHZ)

`endif

//--- verilog/nv_access_pkg.sv
// Types shared by the data-memory access block
package nv_access_pkg;
   typedef enum logic [2:0] {SEL_CTRL, SEL_ADDR, SEL_DATA, SEL_STAT, SEL_NONE} reg_sel_t;
   typedef enum logic {PROG_IDLE, PROG_RUN} prog_state_t;
endpackage : nv_access_pkg

//--- verilog/nv_array_if.sv
// Link between the access controller and the array with its programming engine
`timescale 1ns/100ps
interface nv_array_if #(parameter int ADDR_W = 9, parameter int DATA_W = 8);
   logic start;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic busy;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   modport ctrl (output start, output wr_addr, output wr_data, output rd_addr,
      input busy, input rd_data);
   modport store (input start, input wr_addr, input wr_data, input rd_addr,
      output busy, output rd_data);
endinterface : nv_array_if

//--- verilog/nv_array_store.sv
// Byte array with its self-timed programming engine
`timescale 1ns/100ps
`include "nv_access_defines.svh"
module nv_array_store import nv_access_pkg::*; #(
   parameter int DEPTH = 512,
   parameter int PROG_TICKS = `NV_PROG_OSC_CYCLES
) (
   input wire logic clk,
   input wire logic por_rstn,
   input wire logic osc_tick,
   nv_array_if.store arr
);
   localparam int CNT_W = $clog2(PROG_TICKS + 1);
   localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_TICKS - 1);

   logic [7:0] mem [DEPTH];
   prog_state_t state_r;
   logic [CNT_W-1:0] cnt_r;
   logic [$bits(arr.wr_addr)-1:0] lat_addr_r;
   logic [7:0] lat_data_r;

   wire prog_done = (state_r == PROG_RUN) && osc_tick && (cnt_r == PROG_LAST);

   // Only power-on reset touches the engine, so a system reset lets a write finish
   always_ff @(posedge clk or negedge por_rstn) begin
      if (!por_rstn) begin
         state_r <= PROG_IDLE;
         cnt_r <= '0;
         lat_addr_r <= '0;
         lat_data_r <= '0;
      end else begin
         unique case (state_r)
            PROG_IDLE: begin
               if (arr.start) begin
                  state_r <= PROG_RUN;
                  cnt_r <= '0;
                  lat_addr_r <= arr.wr_addr;
                  lat_data_r <= arr.wr_data;
               end
            end
            PROG_RUN: begin
               if (prog_done) begin
                  state_r <= PROG_IDLE;
               end else if (osc_tick) begin
                  cnt_r <= cnt_r + CNT_W'(1);
               end
            end
         endcase
      end
   end

   // Array content is retained through resets
   always_ff @(posedge clk) begin
      if (prog_done) begin
         mem[lat_addr_r] <= lat_data_r;
      end
   end

   assign arr.busy = (state_r == PROG_RUN);
   assign arr.rd_data = mem[arr.rd_addr];
endmodule : nv_array_store

//--- verilog/eeprom_access_control.sv
// Control of CPU access to the on-chip data byte array over classic Wishbone
`timescale 1ns/100ps
`include "nv_access_defines.svh"
module eeprom_access_control import nv_access_pkg::*; #(
   parameter int DEPTH = 512,
   parameter int ADDR_W = 9,
   parameter int WB_ADR_W = 8,
   parameter int PROG_TICKS = `NV_PROG_OSC_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic por_rstn,
   input wire logic osc_tick,
   input wire logic global_int_flag,
   input wire logic self_prog_active,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [WB_ADR_W-1:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_w,
   output logic [31:0] wb_dat_r,
   output logic wb_ack,
   output logic ready_irq,
   output logic cpu_stall
);

   // The high address byte is always decoded, so at least nine address bits
   if (DEPTH < 2 || DEPTH > (1 << ADDR_W) || ADDR_W < 9 || ADDR_W > 16) begin : g_bad_depth
      $error("eeprom_access_control: DEPTH must fit in ADDR_W bits, ADDR_W from 9 to 16");
   end
   if (WB_ADR_W < 4 || PROG_TICKS < 1) begin : g_bad_misc
      $error("eeprom_access_control: WB_ADR_W below 4 or PROG_TICKS below 1");
   end
   // Counters are three bits wide and use zero as their idle value
   if (`NV_ARM_CYCLES == 0 || `NV_RSTALL_CYCLES == 0 || `NV_WSTALL_CYCLES == 0) begin : g_bad_tm
      $error("eeprom_access_control: arm window and stall counts must be nonzero");
   end

   localparam int ADDR_HI_W = (ADDR_W > 8) ? ADDR_W - 8 : 1;

   // Register decode, used for both the read mux and the write strobes
   function automatic reg_sel_t decode(input logic [WB_ADR_W-1:0] adr);
      reg_sel_t sel;
      sel = SEL_NONE;
      if (adr == WB_ADR_W'(`NV_CTRL_OFF)) sel = SEL_CTRL;
      else if (adr == WB_ADR_W'(`NV_ADDR_OFF)) sel = SEL_ADDR;
      else if (adr == WB_ADR_W'(`NV_DATA_OFF)) sel = SEL_DATA;
      else if (adr == WB_ADR_W'(`NV_STAT_OFF)) sel = SEL_STAT;
      return sel;
   endfunction : decode

   nv_array_if #(.ADDR_W(ADDR_W), .DATA_W(8)) arr ();

   nv_array_store #(
      .DEPTH(DEPTH),
      .PROG_TICKS(PROG_TICKS)
   ) u_store (
      .clk(clk),
      .por_rstn(por_rstn),
      .osc_tick(osc_tick),
      .arr(arr)
   );

   logic ack_r;
   logic rie_r;
   logic arm_r;
   logic [2:0] arm_cnt_r;
   logic [2:0] arm_cnt_nxt;
   logic arm_nxt;
   logic [ADDR_W-1:0] addr_r;
   logic [ADDR_W-1:0] addr_nxt;
   logic [7:0] data_r;
   logic [7:0] data_nxt;
   logic [2:0] stall_r;
   logic [2:0] stall_nxt;
   logic irq_r;
   logic [31:0] rdat_r;

   // Bus access phase: the write acts at the edge where ack is sampled high.
   // Ack stands one cycle, so each access acts exactly once.
   wire req = wb_cyc && wb_stb;
   wire acc = req && ack_r;
   wire acc_wr = acc && wb_we;
   reg_sel_t sel;
   assign sel = decode(wb_adr);

   // One write enable per byte lane of the data bus
   logic [3:0] lane_we;
   for (genvar g = 0; g < 4; g++) begin : g_lane
      assign lane_we[g] = acc_wr && wb_sel[g];
   end

   // Lanes above the ones decoded are accepted and dropped
   wire wr_ctrl = lane_we[0] && (sel == SEL_CTRL);
   wire wr_addr_lo = lane_we[0] && (sel == SEL_ADDR);
   wire wr_addr_hi = lane_we[1] && (sel == SEL_ADDR);
   wire wr_data = lane_we[0] && (sel == SEL_DATA);

   // Fields of a control write; bits 7..4 are never looked at
   wire val_rie = wb_dat_w[`NV_RIE_BIT];
   wire val_arm = wb_dat_w[`NV_ARM_BIT];
   wire val_wstb = wb_dat_w[`NV_WSTB_BIT];
   wire val_rstb = wb_dat_w[`NV_RSTB_BIT];

   // Address halves as they arrive on the bus
   wire [7:0] addr_lo_val = wb_dat_w[7:0];
   wire [ADDR_HI_W-1:0] addr_hi_val = wb_dat_w[8 +: ADDR_HI_W];

   wire busy = arr.busy;
   wire set_arm = wr_ctrl && val_arm;
   wire set_rie = wr_ctrl && val_rie;

   // Strobe counts only while armed, idle and flash programming is not running
   wire wstb_req = wr_ctrl && val_wstb;
   wire wr_start = wstb_req && arm_r && !busy && !self_prog_active;
   wire rd_go = wr_ctrl && val_rstb && !busy;

   // The window closes on the fourth edge after the arming write
   wire arm_expire = arm_r && !set_arm && (arm_cnt_r == 3'h1);

   // Arm window; a new arm in the cycle of timeout wins over the clear
   always_comb begin
      arm_nxt = arm_r;
      arm_cnt_nxt = arm_cnt_r;
      if (set_arm) begin
         arm_nxt = 1'b1;
         arm_cnt_nxt = `NV_ARM_CYCLES;
      end else if (arm_r) begin
         arm_cnt_nxt = arm_cnt_r - 3'h1;
         if (arm_expire) begin
            arm_nxt = 1'b0;
         end
      end
      if (wr_start) begin
         arm_nxt = 1'b0;
         arm_cnt_nxt = 3'h0;
      end
   end

   // Address is frozen while the array is being programmed
   always_comb begin
      addr_nxt = addr_r;
      if (!busy) begin
         if (wr_addr_lo) begin
            addr_nxt[7:0] = addr_lo_val;
         end
         if (wr_addr_hi && ADDR_W > 8) begin
            addr_nxt[ADDR_W-1:8] = addr_hi_val;
         end
      end
   end

   // A read fetch replaces software data in the same cycle
   always_comb begin
      data_nxt = data_r;
      if (wr_data) begin
         data_nxt = wb_dat_w[7:0];
      end
      if (rd_go) begin
         data_nxt = arr.rd_data;
      end
   end

   // Stall counter still running; ack and the stall output both follow it
   wire stall_active = (stall_r != 3'h0);

   always_comb begin
      stall_nxt = stall_active ? stall_r - 3'h1 : 3'h0;
      if (rd_go) begin
         stall_nxt = `NV_RSTALL_CYCLES;
      end else if (wr_start) begin
         stall_nxt = `NV_WSTALL_CYCLES;
      end
   end

   // Read address follows the register at once; the engine keeps its own copy
   assign arr.start = wr_start;
   assign arr.wr_addr = addr_r;
   assign arr.wr_data = data_r;
   assign arr.rd_addr = addr_r;

   // Read-back values of each register; unlisted bits stay zero
   logic [7:0] ctrl_rd;
   logic [7:0] stat_rd;
   always_comb begin
      ctrl_rd = 8'h00;
      ctrl_rd[`NV_RIE_BIT] = rie_r;
      ctrl_rd[`NV_ARM_BIT] = arm_r;
      ctrl_rd[`NV_WSTB_BIT] = busy;
      ctrl_rd[`NV_RSTB_BIT] = 1'b0;
   end
   always_comb begin
      stat_rd = 8'h00;
      stat_rd[`NV_STAT_GIF_BIT] = global_int_flag;
      stat_rd[`NV_STAT_SPM_BIT] = self_prog_active;
      stat_rd[`NV_STAT_IRQ_BIT] = irq_r;
   end
   wire [15:0] addr_rd = 16'(addr_r);
   wire [31:0] rd_mux = (sel == SEL_CTRL) ? {24'h000000, ctrl_rd} :
                        (sel == SEL_ADDR) ? {16'h0000, addr_rd} :
                        (sel == SEL_DATA) ? {24'h000000, data_r} :
                        (sel == SEL_STAT) ? {24'h000000, stat_rd} : 32'h00000000;

   // Ready request while write_strobe is clear, enabled and globally allowed;
   // masked in the start cycle already so no request overlaps the new write
   wire irq_nxt = rie_r && global_int_flag && !busy && !wr_start;

   // Ack is held back during a stall so the CPU really waits
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req && !ack_r && !stall_active;
      end
   end

   // Sampled every cycle so the word stands ready when ack rises
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdat_r <= 32'h00000000;
      end else begin
         rdat_r <= rd_mux;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rie_r <= 1'b0;
      end else if (wr_ctrl) begin
         rie_r <= set_rie;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         arm_r <= 1'b0;
         arm_cnt_r <= 3'h0;
      end else begin
         arm_r <= arm_nxt;
         arm_cnt_r <= arm_cnt_nxt;
      end
   end

   // Defined reset chosen although software must load an address first
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         addr_r <= ADDR_W'(`NV_ADDR_RST);
      end else begin
         addr_r <= addr_nxt;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_r <= `NV_DATA_RST;
      end else begin
         data_r <= data_nxt;
      end
   end

   // A system reset ends a stall early; the array write itself runs on
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stall_r <= 3'h0;
      end else begin
         stall_r <= stall_nxt;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_nxt;
      end
   end

   // Data is forced to zero outside ack so a stale word never leaks
   assign wb_ack = ack_r;
   assign wb_dat_r = ack_r ? rdat_r : 32'h00000000;
   assign ready_irq = irq_r;
   assign cpu_stall = stall_active;

endmodule : eeprom_access_control

//--- testbench/eeprom_access_control_checker.sv
// Port assertions of the data-memory access block
`timescale 1ns/100ps
`include "nv_access_defines.svh"
module eeprom_access_control_checker #(
   parameter int WB_ADR_W = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic por_rstn,
   input wire logic osc_tick,
   input wire logic global_int_flag,
   input wire logic self_prog_active,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [WB_ADR_W-1:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_w,
   input wire logic [31:0] wb_dat_r,
   input wire logic wb_ack,
   input wire logic ready_irq,
   input wire logic cpu_stall
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   wire rd_ack = wb_ack && !wb_we;
   a_ack_one_cycle: assert property (wb_ack |=> !wb_ack) else $error("ack held too long");
   a_ack_has_request: assert property (wb_ack |-> $past(wb_cyc && wb_stb)) else $error("stray ack");
   // Worst case is a request queued behind a read stall
   a_ack_in_time: assert property ($rose(wb_stb) |-> ##[1:6] wb_ack) else $error("ack late");
   a_stall_length: assert property ($rose(cpu_stall) |->
      cpu_stall[*2] ##1 (!cpu_stall or cpu_stall[*2] ##1 !cpu_stall)) else $error("stall length");
   a_stall_no_ack: assert property (cpu_stall |-> !wb_ack) else $error("ack during stall");
   a_irq_needs_gif: assert property (!global_int_flag |=> !ready_irq) else $error("irq ungated");
   a_ctrl_upper_zero: assert property (rd_ack && wb_adr == `NV_CTRL_OFF |->
      wb_dat_r[31:4] == 28'h0) else $error("reserved bits set");
   a_unmapped_zero: assert property (rd_ack && wb_adr > `NV_STAT_OFF |-> wb_dat_r == 32'h0)
      else $error("unmapped read data");
   a_idle_data_zero: assert property (!wb_ack |-> wb_dat_r == 32'h0) else $error("data outside ack");
endmodule : eeprom_access_control_checker
bind eeprom_access_control eeprom_access_control_checker #(.WB_ADR_W(WB_ADR_W)) i_chk (
   .clk(clk), .rstn(rstn), .por_rstn(por_rstn), .osc_tick(osc_tick),
   .global_int_flag(global_int_flag), .self_prog_active(self_prog_active), .wb_cyc(wb_cyc),
   .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
   .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .ready_irq(ready_irq), .cpu_stall(cpu_stall));

//--- testbench/cpu_core_model.sv
// Bus-master model of the CPU core reaching the registers
`timescale 1ns/100ps
module cpu_core_model (
   input wire logic clk,
   input wire logic wb_ack,
   input wire logic [31:0] wb_dat_r,
   output logic wb_cyc,
   output logic wb_stb,
   output logic wb_we,
   output logic [7:0] wb_adr,
   output logic [3:0] wb_sel,
   output logic [31:0] wb_dat_w
);
   initial begin
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_sel = 4'hF;
      wb_dat_w = 32'h0;
   end
   // Waits as long as the slave needs; only the bench watchdog ends a hung access
   task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] d,
         output logic [31:0] q);
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_sel <= 4'hF;
      wb_dat_w <= d;
      do begin
         @(posedge clk);
      end while (wb_ack !== 1'b1);
      q = wb_dat_r;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask : xfer
endmodule : cpu_core_model

//--- testbench/tb_eeprom_access_control.sv
// Self-checking bench of the data-memory access block
`timescale 1ns/100ps
`include "nv_access_defines.svh"
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module tb_eeprom_access_control;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic por_rstn = 1'b0;
   logic osc_tick = 1'b0;
   logic gif = 1'b0;
   logic spa = 1'b0;
   logic wb_cyc, wb_stb, wb_we, wb_ack, ready_irq, cpu_stall;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat_w, wb_dat_r, q;
   logic [3:0] osc_cnt = 4'h0;
   logic [8:0] a;
   logic [7:0] d;
   int n_mismatch = 0;
   int n_checks = 0;
   int seed = 6539;
   eeprom_access_control #(.PROG_TICKS(4)) i_eeprom_access_control (.clk(clk), .rstn(rstn),
      .por_rstn(por_rstn), .osc_tick(osc_tick), .global_int_flag(gif), .self_prog_active(spa),
      .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
      .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .ready_irq(ready_irq),
      .cpu_stall(cpu_stall));
   cpu_core_model i_cpu_core_model (.clk(clk), .wb_ack(wb_ack), .wb_dat_r(wb_dat_r),
      .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
      .wb_dat_w(wb_dat_w));
   initial forever #50 clk = ~clk;
   // Slow oscillator keeps a write busy long enough to poke at it
   always @(posedge clk) begin
      osc_cnt <= osc_cnt + 4'h1;
      osc_tick <= (osc_cnt == 4'hF);
   end
   function automatic logic [31:0] exp_ctrl(input logic rie, input logic arm, input logic busy);
      return {28'h0, rie, arm, busy, 1'b0};
   endfunction : exp_ctrl
   task automatic wr(input logic [7:0] adr, input logic [31:0] v);
      logic [31:0] x;
      i_cpu_core_model.xfer(1'b1, adr, v, x);
   endtask : wr
   task automatic rd(input logic [7:0] adr);
      i_cpu_core_model.xfer(1'b0, adr, 32'h0, q);
   endtask : rd
   task automatic wait_idle;
      int n;
      n = 0;
      do begin
         rd(`NV_CTRL_OFF);
         n++;
      end while (q[1] !== 1'b0 && n < 80);
      `CHK(q[1], 1'b0)
   endtask : wait_idle
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out
   initial begin
      #(100 * 30000);
      n_mismatch++;
      close_out();
   end
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      por_rstn <= 1'b1;
      rd(`NV_CTRL_OFF);
      `CHK(q, exp_ctrl(1'b0, 1'b0, 1'b0))
      wr(`NV_CTRL_OFF, 32'hFFFF_FFF8);
      rd(`NV_CTRL_OFF);
      `CHK(q, exp_ctrl(1'b1, 1'b0, 1'b0))
      gif <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK(ready_irq, 1'b1)
      gif <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(ready_irq, 1'b0)
      for (int i = 0; i < 4; i++) begin
         a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($random(seed));
         d = 8'($random(seed));
         wr(`NV_ADDR_OFF, {23'h0, a});
         wr(`NV_DATA_OFF, {24'h0, d});
         wr(`NV_CTRL_OFF, 32'h4);
         wr(`NV_CTRL_OFF, 32'h2);
         rd(`NV_CTRL_OFF);
         `CHK(q, exp_ctrl(1'b0, 1'b0, 1'b1))
         wr(`NV_ADDR_OFF, {23'h0, ~a});
         wr(`NV_DATA_OFF, {24'h0, ~d});
         wr(`NV_CTRL_OFF, 32'h1);
         rd(`NV_ADDR_OFF);
         `CHK(q[8:0], a)
         rd(`NV_DATA_OFF);
         `CHK(q[7:0], ~d)
         if (i == 2) begin
            rstn <= 1'b0;
            repeat (2) @(posedge clk);
            rstn <= 1'b1;
            rd(`NV_CTRL_OFF);
            `CHK(q[1], 1'b1)
         end
         wait_idle();
         wr(`NV_ADDR_OFF, {23'h0, a});
         wr(`NV_CTRL_OFF, 32'h1);
         rd(`NV_DATA_OFF);
         `CHK(q[7:0], d)
      end
      wr(`NV_CTRL_OFF, 32'h4);
      rd(`NV_CTRL_OFF);
      `CHK(q, exp_ctrl(1'b0, 1'b1, 1'b0))
      rd(`NV_CTRL_OFF);
      `CHK(q, exp_ctrl(1'b0, 1'b0, 1'b0))
      wr(`NV_CTRL_OFF, 32'h2);
      rd(`NV_CTRL_OFF);
      `CHK(q, exp_ctrl(1'b0, 1'b0, 1'b0))
      spa <= 1'b1;
      wr(`NV_CTRL_OFF, 32'h4);
      wr(`NV_CTRL_OFF, 32'h2);
      rd(`NV_CTRL_OFF);
      `CHK(q[1], 1'b0)
      spa <= 1'b0;
      rd(8'h10);
      close_out();
   end
endmodule : tb_eeprom_access_control
